// file: logic/cpurs_core_state.sv
/*
 * Programmer-visible CPU state: general registers with their views,
 * stack pointer role, program counter, extended control register and
 * flag word, with flag updates, reset vector load and address alignment.
 * Assumes decode, ALU and memory interface on the same clock, driving
 * at most one request of each kind per cycle.
 */

`timescale 1ns/1ps
`include "cpurs_map.svh"

module cpurs_core_state (
	input  wire logic                     clk_sys,
	input  wire logic                     sys_rst,
	input  wire logic                     vecValid,
	input  wire logic [23:0]              vecAddr,
	input  wire cpurs_pkg::cpurs_gprwr_s   gprWr,
	input  wire cpurs_pkg::cpurs_rdsel_s   rdSelA,
	input  wire cpurs_pkg::cpurs_rdsel_s   rdSelB,
	input  wire cpurs_pkg::cpurs_spstep_s  spStep,
	input  wire cpurs_pkg::cpurs_pcctl_s   pcCtl,
	input  wire cpurs_pkg::cpurs_aluflag_s aluFlag,
	input  wire cpurs_pkg::cpurs_bitop_s   bitOp,
	input  wire cpurs_pkg::cpurs_daaop_s   daaOp,
	input  wire cpurs_pkg::cpurs_ctlop_s   ctlOp,
	input  wire logic                     excStart,
	input  wire logic                     irqReq,
	input  wire logic                     nmiReq,
	input  wire logic [3:0]               condSel,
	input  wire cpurs_pkg::cpurs_acc_s     accReq,
	input  wire cpurs_pkg::cpurs_class_e   opClass,
	output logic                          vecReq,
	output logic [31:0]                   rdDataA,
	output logic [31:0]                   rdDataB,
	output logic [31:0]                   spValue,
	output logic [23:0]                   pcValue,
	output logic [23:0]                   fetchAddr,
	output logic [23:0]                   memAddr,
	output logic [7:0]                    exrValue,
	output logic [7:0]                    ccrValue,
	output logic                          intAccept,
	output logic                          branchTake,
	output logic                          opRefused
);

	// ------------------------------------------------------------------
	// State and helper nets
	// ------------------------------------------------------------------
	cpurs_pkg::cpurs_state_s st_r;
	cpurs_pkg::cpurs_state_s st_nxt;
	logic                    aluNeg;
	logic                    aluZero;
	logic                    aluHalf;

	// ------------------------------------------------------------------
	// View helpers
	// ------------------------------------------------------------------

	// Read one view of the register set, zero-extended
	function automatic logic [31:0] viewGet(
		input logic [7:0][31:0]     regs,
		input cpurs_pkg::cpurs_size_e size,
		input logic [3:0]           idx
	);
		logic [31:0] w;
		w = regs[idx[2:0]];
		case (size)
			cpurs_pkg::SZ_LONG: viewGet = w;
			cpurs_pkg::SZ_WORD: begin
				if (idx[3]) begin
					viewGet = {16'h0000, w[31:16]};
				end else begin
					viewGet = {16'h0000, w[15:0]};
				end
			end
			default: begin
				if (idx[3]) begin
					viewGet = {24'h000000, w[7:0]};
				end else begin
					viewGet = {24'h000000, w[15:8]};
				end
			end
		endcase
	endfunction

	// Merge one view into a register, leaving other bits alone
	function automatic logic [31:0] viewPut(
		input logic [31:0]          old,
		input cpurs_pkg::cpurs_size_e size,
		input logic [3:0]           idx,
		input logic [31:0]          data
	);
		case (size)
			cpurs_pkg::SZ_LONG: viewPut = data;
			cpurs_pkg::SZ_WORD: begin
				if (idx[3]) begin
					viewPut = {data[15:0], old[15:0]};
				end else begin
					viewPut = {old[31:16], data[15:0]};
				end
			end
			default: begin
				if (idx[3]) begin
					viewPut = {old[31:8], data[7:0]};
				end else begin
					viewPut = {old[31:16], data[7:0], old[7:0]};
				end
			end
		endcase
	endfunction

	// Branch condition from N, Z, V, C
	function automatic logic condEval(
		input logic [3:0] sel,
		input logic [7:0] fw
	);
		logic n;
		logic z;
		logic v;
		logic c;
		n = fw[`CPURS_FW_N];
		z = fw[`CPURS_FW_Z];
		v = fw[`CPURS_FW_V];
		c = fw[`CPURS_FW_C];
		case (sel)
			4'h0:    condEval = 1'b1;
			4'h1:    condEval = 1'b0;
			4'h2:    condEval = ~(c | z);
			4'h3:    condEval = c | z;
			4'h4:    condEval = ~c;
			4'h5:    condEval = c;
			4'h6:    condEval = ~z;
			4'h7:    condEval = z;
			4'h8:    condEval = ~v;
			4'h9:    condEval = v;
			4'ha:    condEval = ~n;
			4'hb:    condEval = n;
			4'hc:    condEval = ~(n ^ v);
			4'hd:    condEval = n ^ v;
			4'he:    condEval = ~(z | (n ^ v));
			default: condEval = z | (n ^ v);
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Flag evaluation of the ALU result
	// ------------------------------------------------------------------
	cpurs_flag_eval u_flag_eval (
		.size (aluFlag.size),
		.opA  (aluFlag.a),
		.opB  (aluFlag.b),
		.res  (aluFlag.r),
		.neg  (aluNeg),
		.zero (aluZero),
		.half (aluHalf)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0]  fw;
		logic [7:0]  xc;
		logic [7:0]  ctlRes;
		logic [7:0]  daaIn;
		logic [7:0]  daaOut;
		logic [7:0]  daaCor;
		logic        bitVal;
		logic        daaHi;
		logic [31:0] spAmt;
		logic [23:0] pcN;
		logic [31:0] daaView;
		fw     = st_r.condition_flags;
		xc     = st_r.extended_control;
		ctlRes = 8'h00;
		daaIn  = 8'h00;
		daaOut = 8'h00;
		daaCor = 8'h00;
		bitVal = 1'b0;
		daaHi  = 1'b0;
		spAmt  = `CPURS_SP_WORD;
		pcN    = st_r.pc;
		daaView = 32'h0000_0000;
		st_nxt = st_r;

		// Read ports sample the state before this cycle's writes
		st_nxt.rdA = viewGet(st_r.gpr, rdSelA.size, rdSelA.idx);
		st_nxt.rdB = viewGet(st_r.gpr, rdSelB.size, rdSelB.idx);

		// Byte moves tied to the peripheral strobe are not supported
		st_nxt.opRefused = (opClass == cpurs_pkg::OC_PERIPH_MOVE);

		if (st_r.phase == cpurs_pkg::PH_VECTOR) begin
			// Wait for the reset vector; register, flag, PC and interrupt updates held off
			st_nxt.vecReq     = ~vecValid;
			st_nxt.intAccept  = 1'b0;
			st_nxt.branchTake = 1'b0;
			if (vecValid) begin
				pcN          = vecAddr;
				st_nxt.phase = cpurs_pkg::PH_RUN;
			end
		end else begin
			st_nxt.vecReq = 1'b0;

			// General register write through one of its views
			if (gprWr.en) begin
				st_nxt.gpr[gprWr.idx[2:0]] = viewPut(
					st_r.gpr[gprWr.idx[2:0]], gprWr.size,
					gprWr.idx, gprWr.data);
			end

			// Implicit stack steps for call, return and exception
			if (spStep.en) begin
				if (spStep.long_) begin
					spAmt = `CPURS_SP_LONG;
				end
				if (spStep.down) begin
					st_nxt.gpr[`CPURS_SP_IDX] =
						st_nxt.gpr[`CPURS_SP_IDX] - spAmt;
				end else begin
					st_nxt.gpr[`CPURS_SP_IDX] =
						st_nxt.gpr[`CPURS_SP_IDX] + spAmt;
				end
			end

			// Decimal adjust of one byte register as two digits
			if (daaOp.valid) begin
				daaView = viewGet(st_r.gpr, cpurs_pkg::SZ_BYTE,
					daaOp.idx);
				daaIn = daaView[7:0];
				daaHi = fw[`CPURS_FW_C] | (daaIn > 8'h99);
				daaCor = {1'b0, daaHi, daaHi, 2'b00,
					(fw[`CPURS_FW_H] | (daaIn[3:0] > 4'h9)),
					(fw[`CPURS_FW_H] | (daaIn[3:0] > 4'h9)),
					1'b0};
				if (daaOp.sub) begin
					daaCor = {1'b0, fw[`CPURS_FW_C],
						fw[`CPURS_FW_C], 2'b00, fw[`CPURS_FW_H],
						fw[`CPURS_FW_H], 1'b0};
					daaOut = daaIn - daaCor;
				end else begin
					daaOut = daaIn + daaCor;
					fw[`CPURS_FW_C] = daaHi;
				end
				st_nxt.gpr[daaOp.idx[2:0]] = viewPut(
					st_nxt.gpr[daaOp.idx[2:0]], cpurs_pkg::SZ_BYTE,
					daaOp.idx, {24'h000000, daaOut});
				fw[`CPURS_FW_N] = daaOut[7];
				fw[`CPURS_FW_Z] = (daaOut == 8'h00);
			end

			// Control-register load and logic ops on either register
			if (ctlOp.valid) begin
				if (ctlOp.toExr) begin
					ctlRes = xc;
				end else begin
					ctlRes = fw;
				end
				case (ctlOp.op)
					cpurs_pkg::CT_LOAD: ctlRes = ctlOp.data;
					cpurs_pkg::CT_AND:  ctlRes = ctlRes & ctlOp.data;
					cpurs_pkg::CT_OR:   ctlRes = ctlRes | ctlOp.data;
					default:            ctlRes = ctlRes ^ ctlOp.data;
				endcase
				if (ctlOp.toExr) begin
					xc = ctlRes | `CPURS_XC_ONES;
				end else begin
					fw = ctlRes;
				end
			end

			// ALU flag update, each flag only when enabled
			if (aluFlag.valid) begin
				if (aluFlag.updH) begin
					fw[`CPURS_FW_H] = aluHalf;
				end
				if (aluFlag.updN) begin
					fw[`CPURS_FW_N] = aluNeg;
				end
				if (aluFlag.updZ) begin
					fw[`CPURS_FW_Z] = aluZero;
				end
				if (aluFlag.updV) begin
					fw[`CPURS_FW_V] = aluFlag.ovf;
				end
				if (aluFlag.updC) begin
					fw[`CPURS_FW_C] = aluFlag.carry;
				end
			end

			// Carry as one-bit accumulator for bit instructions; bit test writes Z instead
			if (bitOp.valid) begin
				bitVal = bitOp.operand[bitOp.num] ^ bitOp.inv;
				case (bitOp.fn)
					cpurs_pkg::BF_LOAD:
						fw[`CPURS_FW_C] = bitVal;
					cpurs_pkg::BF_AND:
						fw[`CPURS_FW_C] = fw[`CPURS_FW_C] & bitVal;
					cpurs_pkg::BF_OR:
						fw[`CPURS_FW_C] = fw[`CPURS_FW_C] | bitVal;
					cpurs_pkg::BF_XOR:
						fw[`CPURS_FW_C] = fw[`CPURS_FW_C] ^ bitVal;
					default:
						fw[`CPURS_FW_Z] = ~bitOp.operand[bitOp.num];
				endcase
			end

			// Exception start sets the mask last so it always wins
			if (excStart) begin
				fw[`CPURS_FW_I] = 1'b1;
			end

			// Program counter: jump load, else one-word step
			if (pcCtl.load) begin
				pcN = pcCtl.addr;
			end else if (pcCtl.step) begin
				pcN = st_r.pc + `CPURS_INSN_STEP;
			end

			// Interrupt acceptance against the mask bit
			st_nxt.intAccept = nmiReq |
				(irqReq & ~st_r.condition_flags[`CPURS_FW_I]);

			// Branch decision on the current N, Z, V, C
			st_nxt.branchTake = condEval(condSel, st_r.condition_flags);
		end

		// Wide data access aligned down, never an error
		if (accReq.valid) begin
			st_nxt.memAddr = accReq.addr;
			if (accReq.wide) begin
				st_nxt.memAddr[0] = 1'b0;
			end
		end

		// Commit registers; fetch address never odd
		st_nxt.pc        = pcN;
		st_nxt.fetchAddr = {pcN[23:1], 1'b0};
		st_nxt.condition_flags       = fw;
		st_nxt.extended_control       = xc | `CPURS_XC_ONES;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Reset touches control state only; general registers stay as found
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r.pc             <= 24'h000000;
			st_r.fetchAddr      <= 24'h000000;
			st_r.memAddr        <= 24'h000000;
			st_r.extended_control            <= `CPURS_XC_RST;
			st_r.condition_flags[`CPURS_FW_I] <= 1'b1;
			st_r.phase          <= cpurs_pkg::PH_VECTOR;
			st_r.vecReq         <= 1'b1;
			st_r.rdA            <= 32'h0000_0000;
			st_r.rdB            <= 32'h0000_0000;
			st_r.intAccept      <= 1'b0;
			st_r.branchTake     <= 1'b0;
			st_r.opRefused      <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign vecReq     = st_r.vecReq;
	assign rdDataA    = st_r.rdA;
	assign rdDataB    = st_r.rdB;
	assign spValue    = st_r.gpr[`CPURS_SP_IDX];
	assign pcValue    = st_r.pc;
	assign fetchAddr  = st_r.fetchAddr;
	assign memAddr    = st_r.memAddr;
	assign exrValue   = st_r.extended_control;
	assign ccrValue   = st_r.condition_flags;
	assign intAccept  = st_r.intAccept;
	assign branchTake = st_r.branchTake;
	assign opRefused  = st_r.opRefused;

endmodule

// file: logic/cpurs_map.svh
/*
 * Register layout, reset values and fixed counts of the CPU state block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CPURS_MAP_SVH
`define CPURS_MAP_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CPURS_GPR_W     32
`define CPURS_GPR_N     8
`define CPURS_PC_W      24
`define CPURS_CTL_W     8
`define CPURS_SP_IDX    3'h7

// ----------------------------------------------------------------------
// Flag word bit positions
// ----------------------------------------------------------------------
`define CPURS_FW_I      7
`define CPURS_FW_UI     6
`define CPURS_FW_H      5
`define CPURS_FW_U      4
`define CPURS_FW_N      3
`define CPURS_FW_Z      2
`define CPURS_FW_V      1
`define CPURS_FW_C      0

// ----------------------------------------------------------------------
// Extended control register layout and reset
// ----------------------------------------------------------------------
`define CPURS_XC_T      7
`define CPURS_XC_ONES   8'h78
`define CPURS_XC_RST    8'h7f

// ----------------------------------------------------------------------
// Half-carry observation points (carry into bit above 3, 11, 27)
// ----------------------------------------------------------------------
`define CPURS_HC_B      4
`define CPURS_HC_W      12
`define CPURS_HC_L      28

// ----------------------------------------------------------------------
// Stack steps, instruction step, decode inventory
// ----------------------------------------------------------------------
`define CPURS_SP_WORD   32'h0000_0002
`define CPURS_SP_LONG   32'h0000_0004
`define CPURS_INSN_STEP 24'h00_0002
`define CPURS_INSN_TYPES 7'h41

`endif

// file: logic/cpurs_pkg.sv
/*
 * Types shared by the CPU state block and its flag evaluator.
 * Assumes cpurs_map.svh is reachable by bare name.
 */
`include "cpurs_map.svh"

package cpurs_pkg;

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cpurs_size_e;
	typedef enum logic [1:0] {CT_LOAD, CT_AND, CT_OR, CT_XOR} cpurs_ctl_e;
	typedef enum logic [2:0] {
		BF_LOAD, BF_AND, BF_OR, BF_XOR, BF_TEST
	} cpurs_bitfn_e;
	typedef enum logic [3:0] {
		OC_NONE, OC_XFER, OC_ARITH, OC_LOGIC, OC_SHIFT, OC_BIT,
		OC_BRANCH, OC_SYSCTL, OC_BLOCK, OC_PERIPH_MOVE
	} cpurs_class_e;
	typedef enum logic {PH_VECTOR, PH_RUN} cpurs_phase_e;

	// ------------------------------------------------------------------
	// Request carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        en;
		cpurs_size_e size;
		logic [3:0]  idx;
		logic [31:0] data;
	} cpurs_gprwr_s;

	typedef struct packed {
		cpurs_size_e size;
		logic [3:0]  idx;
	} cpurs_rdsel_s;

	typedef struct packed {
		logic en;
		logic down;
		logic long_;
	} cpurs_spstep_s;

	typedef struct packed {
		logic        load;
		logic        step;
		logic [23:0] addr;
	} cpurs_pcctl_s;

	typedef struct packed {
		logic        valid;
		cpurs_size_e size;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic        carry;
		logic        ovf;
		logic        updH;
		logic        updN;
		logic        updZ;
		logic        updV;
		logic        updC;
	} cpurs_aluflag_s;

	typedef struct packed {
		logic         valid;
		cpurs_bitfn_e fn;
		logic         inv;
		logic [2:0]   num;
		logic [7:0]   operand;
	} cpurs_bitop_s;

	typedef struct packed {
		logic       valid;
		logic       sub;
		logic [3:0] idx;
	} cpurs_daaop_s;

	typedef struct packed {
		logic       valid;
		cpurs_ctl_e op;
		logic       toExr;
		logic [7:0] data;
	} cpurs_ctlop_s;

	typedef struct packed {
		logic        valid;
		logic        wide;
		logic [23:0] addr;
	} cpurs_acc_s;

	// ------------------------------------------------------------------
	// Whole state of the top module
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0][31:0] gpr;
		logic [23:0]      pc;
		logic [7:0]       extended_control;
		logic [7:0]       condition_flags;
		cpurs_phase_e     phase;
		logic             vecReq;
		logic [31:0]      rdA;
		logic [31:0]      rdB;
		logic [23:0]      fetchAddr;
		logic [23:0]      memAddr;
		logic             intAccept;
		logic             branchTake;
		logic             opRefused;
	} cpurs_state_s;

endpackage

// file: logic/cpurs_flag_eval.sv
/*
 * Sign, zero and half-carry evaluation of an ALU result at a given size.
 * Assumes operands and result arrive from the ALU in the same cycle.
 */
`timescale 1ns/1ps
`include "cpurs_map.svh"

module cpurs_flag_eval (
	input  wire cpurs_pkg::cpurs_size_e size,
	input  wire logic [31:0]            opA,
	input  wire logic [31:0]            opB,
	input  wire logic [31:0]            res,
	output logic                        neg,
	output logic                        zero,
	output logic                        half
);
	logic [31:0] carries;

	// ------------------------------------------------------------------
	// Carry vector holds the carry or borrow into each bit
	// ------------------------------------------------------------------
	assign carries = opA ^ opB ^ res;

	// Size selects sign bit, zero span and half-carry point
	always_comb begin
		case (size)
			cpurs_pkg::SZ_BYTE: begin
				neg  = res[7];
				zero = (res[7:0] == 8'h00);
				half = carries[`CPURS_HC_B];
			end
			cpurs_pkg::SZ_WORD: begin
				neg  = res[15];
				zero = (res[15:0] == 16'h0000);
				half = carries[`CPURS_HC_W];
			end
			default: begin
				neg  = res[31];
				zero = (res == 32'h0000_0000);
				half = carries[`CPURS_HC_L];
			end
		endcase
	end

endmodule

// file: tb/cpurs_core_state_assertions.sv
/* Checker of the CPU state block on its top-level ports.
   Assumes it is bound into every cpurs_core_state instance. */
`timescale 1ns/1ps
module cpurs_core_state_assertions (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire logic                   excStart,
	input wire logic                   irqReq,
	input wire logic                   nmiReq,
	input wire cpurs_pkg::cpurs_acc_s   accReq,
	input wire cpurs_pkg::cpurs_class_e opClass,
	input wire logic                   vecReq,
	input wire logic [23:0]            pcValue,
	input wire logic [23:0]            fetchAddr,
	input wire logic [23:0]            memAddr,
	input wire logic [7:0]             exrValue,
	input wire logic [7:0]             ccrValue,
	input wire logic                   intAccept,
	input wire logic                   opRefused
);
	// ------------------------------
	// Properties on the system clock
	// ------------------------------
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_exr_ones:
		assert property (exrValue[6:3] == 4'hf)
		else $error("extended bits 6:3 not all one");
	a_fetch_even:
		assert property (fetchAddr == {pcValue[23:1], 1'h0})
		else $error("fetch address not even");
	a_nmi_accept:
		assert property (nmiReq && !vecReq |=> intAccept)
		else $error("non-maskable request not accepted");
	a_irq_masked:
		assert property (irqReq && !nmiReq && ccrValue[7] |=> !intAccept)
		else $error("masked request accepted");
	a_exc_mask:
		assert property (excStart && !vecReq |=> ccrValue[7])
		else $error("mask bit not set by exception start");
	a_reset_values:
		assert property ($fell(sys_rst) |-> vecReq && pcValue == 24'h0
			&& exrValue == 8'h7f && ccrValue[7])
		else $error("state after reset wrong");
	a_wide_align:
		assert property (accReq.valid && accReq.wide |=>
			memAddr == ($past(accReq.addr) & 24'hff_fffe))
		else $error("wide access address not aligned");
	a_periph_flag:
		assert property (opClass == cpurs_pkg::OC_PERIPH_MOVE |=> opRefused)
		else $error("peripheral move not refused");
	// Main scenarios reached
	c_irq: cover property (intAccept);
	c_refused: cover property (opRefused);
	c_vector: cover property (vecReq ##1 !vecReq);
endmodule

bind cpurs_core_state cpurs_core_state_assertions u_chk (
	.clk_sys, .sys_rst, .excStart, .irqReq, .nmiReq, .accReq, .opClass,
	.vecReq, .pcValue, .fetchAddr, .memAddr, .exrValue, .ccrValue,
	.intAccept, .opRefused
);

// file: tb/tb_cpu_register_state.sv
/* Self-checking bench of the CPU state block, one task per scenario.
   Assumes the package, map header and checker are compiled first. */
`timescale 1ns/1ps
module tb_cpu_register_state;
	logic                     clk_sys, sys_rst, vecValid, excStart;
	logic                     irqReq, nmiReq, vecReq, intAccept;
	logic                     branchTake, opRefused;
	logic [23:0]              vecAddr, pcValue, fetchAddr, memAddr;
	logic [31:0]              rdDataA, rdDataB, spValue;
	logic [7:0]               exrValue, ccrValue;
	logic [3:0]               condSel;
	cpurs_pkg::cpurs_gprwr_s   gprWr;
	cpurs_pkg::cpurs_rdsel_s   rdSelA, rdSelB;
	cpurs_pkg::cpurs_spstep_s  spStep;
	cpurs_pkg::cpurs_pcctl_s   pcCtl;
	cpurs_pkg::cpurs_daaop_s   daaOp;
	cpurs_pkg::cpurs_aluflag_s aluFlag;
	cpurs_pkg::cpurs_bitop_s   bitOp;
	cpurs_pkg::cpurs_ctlop_s   ctlOp;
	cpurs_pkg::cpurs_acc_s     accReq;
	cpurs_pkg::cpurs_class_e   opClass;
	int                       n_errors, n_checks;

	cpurs_core_state dut (
		.clk_sys, .sys_rst, .vecValid, .vecAddr, .gprWr, .rdSelA,
		.rdSelB, .spStep, .pcCtl, .aluFlag, .bitOp, .daaOp,
		.ctlOp, .excStart, .irqReq, .nmiReq, .condSel, .accReq, .opClass,
		.vecReq, .rdDataA, .rdDataB, .spValue, .pcValue, .fetchAddr,
		.memAddr, .exrValue, .ccrValue, .intAccept, .branchTake, .opRefused
	);

	// 100 ns system clock
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	// -------------
	// Shared tasks
	// -------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Drop one-cycle requests, then sample settled outputs
	task automatic tick();
		@(posedge clk_sys);
		gprWr    <= '0;
		spStep   <= '0;
		pcCtl    <= '0;
		daaOp    <= '0;
		aluFlag  <= '0;
		bitOp    <= '0;
		ctlOp    <= '0;
		accReq   <= '0;
		vecValid <= 1'h0;
		excStart <= 1'h0;
		irqReq   <= 1'h0;
		nmiReq   <= 1'h0;
		opClass  <= cpurs_pkg::OC_NONE;
		@(negedge clk_sys);
	endtask
	task automatic wr(cpurs_pkg::cpurs_size_e s, logic [3:0] i, logic [31:0] d);
		@(posedge clk_sys);
		gprWr <= '{1'h1, s, i, d};
		tick();
	endtask
	task automatic rd(cpurs_pkg::cpurs_size_e s, logic [3:0] i, logic [31:0] e);
		@(posedge clk_sys);
		rdSelA <= '{s, i};
		rdSelB <= '{s, i};
		tick();
		chk("rdDataA", rdDataA, e);
		chk("rdDataB", rdDataB, e);
	endtask
	task automatic ctl(cpurs_pkg::cpurs_ctl_e op, logic x, logic [7:0] d);
		@(posedge clk_sys);
		ctlOp <= '{1'h1, op, x, d};
		tick();
	endtask
	task automatic alu(logic [31:0] a, b, r, logic c, v);
		@(posedge clk_sys);
		aluFlag <= {1'h1, cpurs_pkg::SZ_BYTE, a, b, r, c, v, 5'h1f};
		tick();
	endtask

	// ---------
	// Scenarios
	// ---------
	task automatic t_reset();
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(negedge clk_sys);
		chk("exrValue", exrValue, 8'h7f);
		chk("maskBit", ccrValue[7], 1'h1);
		chk("vecReq", vecReq, 1'h1);
		@(posedge clk_sys);
		vecValid <= 1'h1;
		vecAddr  <= 24'h12_3457;
		tick();
		chk("pcValue", pcValue, 24'h12_3457);
		chk("vecReq", vecReq, 1'h0);
		chk("fetchAddr", fetchAddr, 24'h12_3456);
	endtask
	task automatic t_views();
		wr(cpurs_pkg::SZ_LONG, 4'h2, 32'h89ab_cdef);
		rd(cpurs_pkg::SZ_LONG, 4'h2, 32'h89ab_cdef);
		rd(cpurs_pkg::SZ_WORD, 4'ha, 32'h89ab);
		rd(cpurs_pkg::SZ_WORD, 4'h2, 32'hcdef);
		rd(cpurs_pkg::SZ_BYTE, 4'h2, 32'hcd);
		rd(cpurs_pkg::SZ_BYTE, 4'ha, 32'hef);
		wr(cpurs_pkg::SZ_BYTE, 4'ha, 32'h5a);
		rd(cpurs_pkg::SZ_LONG, 4'h2, 32'h89ab_cd5a);
	endtask
	task automatic t_stack();
		wr(cpurs_pkg::SZ_LONG, 4'h7, 32'h1000);
		@(posedge clk_sys);
		spStep <= '{1'h1, 1'h1, 1'h1};
		tick();
		chk("spValue", spValue, 32'hffc);
	endtask
	task automatic t_flags();
		ctl(cpurs_pkg::CT_LOAD, 1'h0, 8'h00);
		ctl(cpurs_pkg::CT_OR, 1'h0, 8'h50);
		chk("ccrValue", ccrValue, 8'h50);
		alu(32'h0f, 32'h01, 32'h10, 1'h0, 1'h0);
		chk("ccrValue", ccrValue, 8'h70);
		alu(32'h80, 32'h80, 32'h00, 1'h1, 1'h1);
		chk("ccrValue", ccrValue, 8'h57);
		@(posedge clk_sys);
		condSel <= 4'h7;
		tick();
		chk("branchTake", branchTake, 1'h1);
		alu(32'h70, 32'h10, 32'h80, 1'h0, 1'h1);
		chk("ccrValue", ccrValue, 8'h5a);
		@(posedge clk_sys);
		bitOp <= '{1'h1, cpurs_pkg::BF_LOAD, 1'h0, 3'h3, 8'h08};
		tick();
		chk("ccrValue", ccrValue, 8'h5b);
	endtask
	task automatic t_intr();
		@(posedge clk_sys);
		irqReq <= 1'h1;
		tick();
		chk("intAccept", intAccept, 1'h1);
		@(posedge clk_sys);
		excStart <= 1'h1;
		tick();
		chk("ccrValue", ccrValue, 8'hdb);
		@(posedge clk_sys);
		irqReq <= 1'h1;
		tick();
		chk("intAccept", intAccept, 1'h0);
		@(posedge clk_sys);
		nmiReq <= 1'h1;
		tick();
		chk("intAccept", intAccept, 1'h1);
	endtask
	task automatic t_misc();
		ctl(cpurs_pkg::CT_XOR, 1'h1, 8'h87);
		chk("exrValue", exrValue, 8'hf8);
		@(posedge clk_sys);
		accReq  <= '{1'h1, 1'h1, 24'h00_0101};
		opClass <= cpurs_pkg::OC_PERIPH_MOVE;
		tick();
		chk("memAddr", memAddr, 24'h00_0100);
		chk("opRefused", opRefused, 1'h1);
		@(posedge clk_sys);
		pcCtl <= '{1'h0, 1'h1, 24'h00_0000};
		tick();
		chk("pcValue", pcValue, 24'h12_3459);
		chk("fetchAddr", fetchAddr, 24'h12_3458);
		@(posedge clk_sys);
		pcCtl <= '{1'h1, 1'h1, 24'h00_0200};
		tick();
		chk("pcValue", pcValue, 24'h00_0200);
	endtask
	// Decimal adjust after add, then after subtract, on a high byte
	task automatic t_daa();
		ctl(cpurs_pkg::CT_LOAD, 1'h0, 8'h00);
		wr(cpurs_pkg::SZ_BYTE, 4'h3, 32'h9a);
		@(posedge clk_sys);
		daaOp <= '{1'h1, 1'h0, 4'h3};
		tick();
		rd(cpurs_pkg::SZ_BYTE, 4'h3, 32'h00);
		chk("ccrValue", ccrValue, 8'h05);
		@(posedge clk_sys);
		daaOp <= '{1'h1, 1'h1, 4'h3};
		tick();
		rd(cpurs_pkg::SZ_BYTE, 4'h3, 32'ha0);
		chk("ccrValue", ccrValue, 8'h09);
	endtask

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hung run
	initial begin
		repeat (500) @(posedge clk_sys);
		n_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		n_errors = 0;
		n_checks = 0;
		sys_rst  = 1'h1;
		{vecValid, excStart, irqReq, nmiReq} = 4'h0;
		{vecAddr, condSel, gprWr, rdSelA, spStep} = '0;
		{aluFlag, bitOp, ctlOp, accReq, pcCtl, daaOp, rdSelB} = '0;
		opClass = cpurs_pkg::OC_NONE;
		t_reset();
		t_views();
		t_stack();
		t_flags();
		t_intr();
		t_misc();
		t_daa();
		give_verdict();
	end
endmodule
